/* hw/idle_cmd_host.sv */
/*
  Host controller that drives the transceiver over its serial slave pins
  and wake input: power-up wake pulse, idle frames, register read and
  register write. Assumes the device answers in SPI mode 0 and that a
  reply is read by a second selected transfer once the device lowers
  its ready line (active low irq_out_n).
*/
// Overview of operation
// - Idle frame: 07, 0E, then control words
// - Enter word: 0400 hibernate, 0142 sleep
// - Wake word: 0400 hibernate, 3800 sleep
// - Leave word 1800 for hibernate
// - Host always enables pin wake source
// - Host pulses wake pin low after power-on
// - Host ignores wake flag after hibernate/POR
// - Read frame: 08, 03, address, 01, 00
// - Set analog index 04 before reading
// - Host writes zero to bits 7:6
`include "idle_cmd_params.svh"
`timescale 1ns/100ps
`default_nettype none
module idle_cmd_host
  import idle_cmd_pkg::*;
#(
  parameter int unsigned READY_CYC = `READY_DELAY_US * `CLK_MHZ // Wake delay
)
(
  input wire logic clock, // System clock
  input wire logic arst_n, // Asynchronous reset
  input wire logic [3:0] addr, // Software address
  input wire logic [7:0] wdata, // Software write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  output spi_out_t pins, // Serial and wake pins to device
  input wire logic miso, // Device serial out
  input wire logic irq_out_n // Device reply ready, low
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_PULSE = 3'h1,
    S_SEND = 3'h2,
    S_WAIT = 3'h3,
    S_RECV = 3'h4,
    S_DELAY = 3'h5
  } st_t;

  localparam int unsigned PULSE_CYC = `WAKE_PULSE_NS * `CLK_MHZ / 1000;

  logic rst_a_ff, rst_ff;
  logic [1:0] miso_s_ff, irq_s_ff;
  st_t st_ff;
  op_t op_ff;
  logic [7:0] arg_ff;
  logic [7:0] frame_ff [16];
  logic [4:0] nbytes_ff, byte_ff;
  logic [2:0] bit_ff;
  logic [3:0] div_ff;
  logic [19:0] cnt_ff;
  reply_t rep_ff;
  logic busy_ff, ready_ff, badlen_ff;
  logic [7:0] shift_ff;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_a_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_ff <= rst_a_ff;
    end
  end

  always_ff @(posedge clock or negedge rst_ff) begin
    if (!rst_ff) begin
      miso_s_ff <= 2'h0;
      irq_s_ff <= 2'h3;
    end else begin
      miso_s_ff <= {miso_s_ff[0], miso};
      irq_s_ff <= {irq_s_ff[0], irq_out_n};
    end
  end

  // A wake pulse is still taken while an idle command awaits its reply
  wire start = wr && addr == `OFF_CTRL && (!busy_ff ||
    (st_ff == S_WAIT && op_t'(wdata[2:0]) == OP_WAKE_PULSE));
  wire tick = div_ff == `SCLK_DIV;
  wire [3:0] tx_byte_idx = byte_ff[3:0] + {3'h0, bit_ff == 3'h7};
  wire tx_bit = frame_ff[tx_byte_idx][3'h6 - bit_ff];
  wire [7:0] analog_val = arg_ff & ~`ANALOG_RSV_MASK;

  // Frame builder, loaded on a start
  always_ff @(posedge clock or negedge rst_ff) begin
    if (!rst_ff) begin
      for (int i = 0; i < 16; i++) begin
        frame_ff[i] <= 8'h00;
      end
      nbytes_ff <= 5'h0;
    end else if (start) begin
      for (int i = 0; i < 16; i++) begin
        frame_ff[i] <= 8'h00;
      end
      case (op_t'(wdata[2:0]))
        OP_IDLE_HIB: begin
          frame_ff[0] <= `CODE_IDLE;
          frame_ff[1] <= `LEN_IDLE;
          frame_ff[2] <= `WAKE_PIN;
          frame_ff[3] <= 8'(`ENTER_HIB >> 8);
          frame_ff[4] <= 8'(`ENTER_HIB);
          frame_ff[5] <= 8'(`WAKECTL_HIB >> 8);
          frame_ff[6] <= 8'(`WAKECTL_HIB);
          frame_ff[7] <= 8'(`EXIT_CTL >> 8);
          frame_ff[8] <= 8'(`EXIT_CTL);
          nbytes_ff <= 5'h10;
        end
        OP_IDLE_SLEEP: begin
          frame_ff[0] <= `CODE_IDLE;
          frame_ff[1] <= `LEN_IDLE;
          frame_ff[2] <= `WAKE_FIELD | `WAKE_PIN;
          frame_ff[3] <= 8'(`ENTER_SLEEP >> 8);
          frame_ff[4] <= 8'(`ENTER_SLEEP);
          frame_ff[5] <= 8'(`WAKECTL_SLEEP >> 8);
          frame_ff[6] <= 8'(`WAKECTL_SLEEP);
          frame_ff[7] <= 8'(`EXIT_CTL >> 8);
          frame_ff[8] <= 8'(`EXIT_CTL);
          nbytes_ff <= 5'h10;
        end
        OP_READ_WAKE, OP_READ_ANALOG: begin
          frame_ff[0] <= `CODE_REGISTER_READ_CMD;
          frame_ff[1] <= `LEN_REGISTER_READ_CMD;
          frame_ff[2] <= wdata[0] ? `ADDR_ANALOG_REG : `ADDR_WAKE_REG;
          frame_ff[3] <= `REG_SIZE_ONE;
          nbytes_ff <= 5'h5;
        end
        OP_WRITE_ANALOG: begin
          frame_ff[0] <= `CODE_REGISTER_WRITE_CMD;
          frame_ff[1] <= arg_ff[7] ? `LEN_REGISTER_WRITE_CMD_IDX : `LEN_REGISTER_WRITE_CMD_VAL;
          frame_ff[2] <= `ADDR_ANALOG_IDX;
          frame_ff[3] <= arg_ff[7] ? 8'h00 : 8'h01;
          frame_ff[4] <= `ANALOG_IDX_VAL;
          frame_ff[5] <= analog_val;
          nbytes_ff <= arg_ff[7] ? 5'h5 : 5'h6;
        end
        default: nbytes_ff <= 5'h0;
      endcase
    end
  end

  // Sequencer
  always_ff @(posedge clock or negedge rst_ff) begin
    if (!rst_ff) begin
      st_ff <= S_IDLE;
      op_ff <= OP_NONE;
      busy_ff <= 1'b0;
      ready_ff <= 1'b0;
      cnt_ff <= 20'h0;
      div_ff <= 4'h0;
      bit_ff <= 3'h0;
      byte_ff <= 5'h0;
      pins <= '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1, wake_n: 1'b1};
      rep_ff <= '0;
      shift_ff <= 8'h00;
      badlen_ff <= 1'b0;
    end else begin
      div_ff <= tick ? 4'h0 : div_ff + 4'h1;
      case (st_ff)
        S_IDLE: begin
          if (start) begin
            op_ff <= op_t'(wdata[2:0]);
            busy_ff <= 1'b1;
            byte_ff <= 5'h0;
            bit_ff <= 3'h0;
            cnt_ff <= 20'h0;
            if (op_t'(wdata[2:0]) == OP_WAKE_PULSE) begin
              st_ff <= S_PULSE;
              pins.wake_n <= 1'b0;
            end else if (ready_ff && !(wdata[2:0] inside {3'h0, 3'h7})) begin
              st_ff <= S_SEND;
              pins.cs_n <= 1'b0;
              pins.mosi <= 1'b0; // Every command code has bit 7 clear
            end else begin
              busy_ff <= 1'b0;
            end
          end
        end
        S_PULSE: begin
          cnt_ff <= cnt_ff + 20'h1;
          if (cnt_ff == 20'(PULSE_CYC - 1)) begin
            pins.wake_n <= 1'b1;
            cnt_ff <= 20'h0;
            st_ff <= (op_ff == OP_WAKE_PULSE) ? S_DELAY : S_WAIT;
          end
        end
        S_DELAY: begin
          cnt_ff <= cnt_ff + 20'h1;
          if (cnt_ff == 20'(READY_CYC - 1)) begin
            ready_ff <= 1'b1;
            busy_ff <= 1'b0;
            st_ff <= S_IDLE;
          end
        end
        S_SEND: if (tick) begin
          pins.sclk <= ~pins.sclk;
          // Data moves on the falling edge, clear of the sampling edge
          if (pins.sclk) begin
            pins.mosi <= tx_bit;
            bit_ff <= bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              byte_ff <= byte_ff + 5'h1;
              if (byte_ff == nbytes_ff - 5'h1) begin
                pins.cs_n <= 1'b1;
                st_ff <= S_WAIT;
                // an idle leaves the device in wait until it replies
                ready_ff <= !(op_ff == OP_IDLE_HIB ||
                              op_ff == OP_IDLE_SLEEP);
              end
            end
          end
        end
        // Select on a tick so the first reply bit clears the synchroniser
        S_WAIT: if (!irq_s_ff[1] && tick) begin
          st_ff <= S_RECV;
          pins.cs_n <= 1'b0;
          byte_ff <= 5'h0;
          bit_ff <= 3'h0;
        end else if (start) begin
          st_ff <= S_PULSE;
          pins.wake_n <= 1'b0;
        end
        S_RECV: if (tick) begin
          pins.sclk <= ~pins.sclk;
          if (!pins.sclk) begin
            shift_ff <= {shift_ff[6:0], miso_s_ff[1]};
          end else if (bit_ff == 3'h7) begin
            bit_ff <= 3'h0;
            byte_ff <= byte_ff + 5'h1;
            case (byte_ff[1:0])
              2'h0: rep_ff.code <= shift_ff;
              2'h1: rep_ff.len <= shift_ff;
              default: rep_ff.data <= shift_ff;
            endcase
            if ((byte_ff == 5'h1 && shift_ff == 8'h00) || byte_ff == 5'h2)
            begin
              badlen_ff <= rep_ff.code == `RES_BADLEN;
              // wake flag after hibernate carries no meaning; no data
              if (op_ff == OP_IDLE_HIB || !byte_ff[1]) rep_ff.data <= 8'h00;
              pins.cs_n <= 1'b1;
              ready_ff <= 1'b1;
              busy_ff <= 1'b0;
              st_ff <= S_IDLE;
            end
          end else begin
            bit_ff <= bit_ff + 3'h1;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_ff) begin
    if (!rst_ff) begin
      arg_ff <= `ARG_RESET;
    end else if (wr && addr == `OFF_ARG) begin
      arg_ff <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_ff) begin
    if (!rst_ff) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `OFF_ARG: rdata <= arg_ff;
        `OFF_STATUS: rdata <= {5'h0, badlen_ff, ready_ff, busy_ff};
        `OFF_RESULT: rdata <= rep_ff.code;
        `OFF_DATA: rdata <= rep_ff.data;
        default: rdata <= 8'h00;
      endcase
    end
  end

  property p_pulse_len;
    @(posedge clock) disable iff (!rst_ff)
      $fell(pins.wake_n) |-> !pins.wake_n [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("wake pulse too short");

  property p_reserved_zero;
    @(posedge clock) disable iff (!rst_ff)
      (st_ff == S_SEND && op_ff == OP_WRITE_ANALOG && !arg_ff[7])
      |-> frame_ff[5][7:6] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved analog bits set");

  property p_pin_source;
    @(posedge clock) disable iff (!rst_ff)
      (st_ff == S_SEND && op_ff inside {OP_IDLE_HIB, OP_IDLE_SLEEP})
      |-> frame_ff[2][3] && frame_ff[0] == 8'h07 && frame_ff[1] == 8'h0E;
  endproperty
  a_pin_source: assert property (p_pin_source)
    else $error("idle frame lacks pin source");

  property p_no_send_waiting;
    @(posedge clock) disable iff (!rst_ff)
      st_ff == S_IDLE && start && !ready_ff |=> st_ff != S_SEND;
  endproperty
  a_no_send_waiting: assert property (p_no_send_waiting)
    else $error("command while device not ready");
  property p_wait_not_ready;
    @(posedge clock) disable iff (!rst_ff)
      st_ff == S_WAIT && op_ff inside {OP_IDLE_HIB, OP_IDLE_SLEEP} |-> !ready_ff;
  endproperty
  a_wait_not_ready: assert property (p_wait_not_ready)
    else $error("ready while device in wait mode");
  property p_ready_delay;
    @(posedge clock) disable iff (!rst_ff)
      st_ff == S_DELAY && cnt_ff != 20'(READY_CYC - 1) && !ready_ff |=> !ready_ff;
  endproperty
  a_ready_delay: assert property (p_ready_delay)
    else $error("ready before wake delay ended");

  c_idle: cover property (@(posedge clock) st_ff == S_WAIT);
  c_pulse: cover property (@(posedge clock) $rose(ready_ff));
  c_read: cover property (@(posedge clock)
    op_ff == OP_READ_ANALOG && $fell(busy_ff));
endmodule
`default_nettype wire

/* hw/idle_cmd_params.svh */
/*
  Constants of the host-side command sequencer: command codes, frame
  fields, register addresses and timing counts.
  Assumes a 100 MHz system clock.
*/
`ifndef IDLE_CMD_PARAMS_SVH
`define IDLE_CMD_PARAMS_SVH

`define CODE_IDLE 8'h07
`define LEN_IDLE 8'h0E
`define CODE_REGISTER_READ_CMD 8'h08
`define LEN_REGISTER_READ_CMD 8'h03
`define CODE_REGISTER_WRITE_CMD 8'h09
`define LEN_REGISTER_WRITE_CMD_IDX 8'h03
`define LEN_REGISTER_WRITE_CMD_VAL 8'h04
`define ADDR_WAKE_REG 8'h62
`define ADDR_ANALOG_REG 8'h69
`define ADDR_ANALOG_IDX 8'h68
`define ANALOG_IDX_VAL 8'h04
`define REG_SIZE_ONE 8'h01
`define WAKE_FIELD 8'h04
`define WAKE_PIN 8'h08
`define ENTER_HIB 16'h0400
`define ENTER_SLEEP 16'h0142
`define WAKECTL_HIB 16'h0400
`define WAKECTL_SLEEP 16'h3800
`define EXIT_CTL 16'h1800
`define RES_OK 8'h00
`define RES_BADLEN 8'h82
`define ANALOG_RSV_MASK 8'hC0
`define CLK_MHZ 100
`define READY_DELAY_US 6000
`define WAKE_PULSE_NS 20000
`define SCLK_DIV 4'h4
`define ARG_RESET 8'h07

// Software port offsets
`define OFF_CTRL 4'h0
`define OFF_ARG 4'h1
`define OFF_STATUS 4'h2
`define OFF_RESULT 4'h3
`define OFF_DATA 4'h4

`endif

/* hw/idle_cmd_pkg.sv */
/*
  Types of the host-side command sequencer.
  Assumes the params header supplies all numeric constants.
*/
package idle_cmd_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_WAKE_PULSE = 3'h1,
    OP_IDLE_HIB = 3'h2,
    OP_IDLE_SLEEP = 3'h3,
    OP_READ_WAKE = 3'h4,
    OP_READ_ANALOG = 3'h5,
    OP_WRITE_ANALOG = 3'h6
  } op_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
    logic wake_n;
  } spi_out_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] len;
    logic [7:0] data;
  } reply_t;
endpackage

/* verification/dev_model.sv */
/*
  Device model: command decoder behind SPI mode 0 slave pins.
  Assumes the host frames a command, then reads the reply after irq_out_n.
*/
`timescale 1ns/100ps
`default_nettype none
module dev_model #(
  parameter int READY_NS = 6000000 // Power-up to ready delay
) (
  input wire logic sclk, // Serial clock
  input wire logic mosi, // Host data
  input wire logic cs_n, // Select, low
  input wire logic wake_n, // Wake pin, low
  input wire logic field, // RF field seen
  input wire logic bad_len, // Answer reads with error
  output logic miso, // Device data
  output logic irq_out_n // Reply ready, low
);
  logic [7:0] rx [0:31];
  logic [7:0] sh, d, wake_src = 8'h00, analog = 8'h27, idx = 8'h00;
  logic [23:0] txv = 24'h0;
  logic waiting = 0, ready = 0;
  int nb, nbit, ob;
  initial irq_out_n = 1;
  // Deselected line shows the inverse, not a stale bit
  assign miso = txv[23 - (ob % 24)] ^ cs_n;
  task automatic reply(logic [23:0] v);
    txv = v;
    irq_out_n = 0;
  endtask
  always @(negedge cs_n) begin
    ob = 0;
    nb = 0;
    nbit = 0;
  end
  always @(negedge sclk) if (!cs_n) ob++;
  always @(posedge sclk) begin
    if (!cs_n && irq_out_n) begin
      sh = {sh[6:0], mosi};
      nbit++;
      if (nbit == 8) begin
        rx[nb % 32] = sh;
        nb++;
        nbit = 0;
      end
    end
  end
  always @(posedge cs_n) begin
    if (!irq_out_n) irq_out_n = 1;
    else if (ready && !waiting) begin
      case (rx[0])
        8'h07: begin
          wake_src = rx[2];
          waiting = 1;
        end
        8'h08: begin
          d = (idx == 8'h04) ? analog : 8'hFF;
          if (rx[2] == 8'h62) d = wake_src;
          if (bad_len || rx[1] != 8'h03) reply(24'h820000);
          else reply({16'h0001, d});
        end
        8'h09: begin
          if (rx[1] == 8'h04) analog = rx[5];
          else idx = rx[4];
          reply(24'h0);
        end
        default: ;
      endcase
    end
  end
  always @(negedge wake_n) begin
    if (waiting && wake_src[3]) begin
      waiting = 0;
      reply(24'h000108);
    end else if (!ready) begin
      #READY_NS ready = 1;
    end
  end
  // Field wakes only a sleep entered with the field source enabled
  always @(posedge field) begin
    if (waiting && wake_src[2] && rx[4] == 8'h42) begin
      waiting = 0;
      reply(24'h000104);
    end
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
/*
  Bench for the host command sequencer against the device model.
  Assumes the params header and package are compiled before it.
*/
`include "idle_cmd_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  import idle_cmd_pkg::*;
  logic clock = 0, arst_n = 0, wr = 0, rd = 0, field = 0, bad_len = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, q;
  spi_out_t pins;
  logic miso, irq_out_n;
  int failures = 0, check_count = 0;
  always #5 clock = ~clock;
  // Shortened wake delay keeps the run short; model is ready before host
  idle_cmd_host #(.READY_CYC(3000)) uut (.clock(clock), .arst_n(arst_n),
    .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pins(pins),
    .miso(miso), .irq_out_n(irq_out_n));
  dev_model #(.READY_NS(20000)) dev (.sclk(pins.sclk), .mosi(pins.mosi),
    .cs_n(pins.cs_n),
    .wake_n(pins.wake_n), .field(field), .bad_len(bad_len), .miso(miso),
    .irq_out_n(irq_out_n));
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge clock);
    wr <= 0;
  endtask
  task automatic rreg(logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1;
    @(posedge clock);
    rd <= 0;
    #1 q = rdata;
  endtask
  task automatic wait_stat(logic [7:0] m, logic [7:0] v, int n);
    for (int i = 0; i < n; i++) begin
      rreg(`OFF_STATUS);
      if ((q & m) === v) return;
    end
    chk("status wait", q & m, v);
  endtask
  task automatic run(logic [7:0] o);
    wreg(`OFF_CTRL, o);
    wait_stat(8'h01, 8'h00, 5000);
  endtask
  task automatic frm(logic [71:0] e, int n);
    for (int i = 0; i < n; i++)
      chk("frame byte", dev.rx[i], e[8*(n-1-i) +: 8]);
  endtask
  task automatic res(logic [7:0] c, logic [7:0] v);
    rreg(`OFF_RESULT);
    chk("result", q, c);
    rreg(`OFF_DATA);
    chk("data", q, v);
  endtask
  task automatic t_reset();
    rreg(`OFF_STATUS);
    chk("status", q, 8'h00);
    wreg(4'hF, 8'h55);
    rreg(`OFF_ARG);
    chk("arg", q, `ARG_RESET);
    run(4);
    chk("refused", q, 8'h00);
  endtask
  task automatic t_wake();
    time t0;
    wreg(`OFF_CTRL, 8'h01);
    @(negedge pins.wake_n);
    t0 = $time;
    @(posedge pins.wake_n);
    chk("pulse", 16'(($time - t0) / 10), `WAKE_PULSE_NS / 10);
    rreg(`OFF_STATUS);
    chk("not ready", q & 8'h02, 8'h00);
    wait_stat(8'h03, 8'h02, 5000);
    chk("ready", q & 8'h03, 8'h02);
  endtask
  task automatic t_analog();
    logic [7:0] v [3] = '{8'h01, 8'h27, 8'h6F};
    logic [7:0] e [3] = '{8'h01, 8'h27, 8'h2F};
    wreg(`OFF_ARG, 8'h84);
    run(6);
    frm(72'h0903680004, 5);
    for (int i = 0; i < 3; i++) begin
      wreg(`OFF_ARG, v[i]);
      run(6);
      frm({40'h0904680104, e[i]}, 6);
      chk("analog", dev.analog, e[i]);
    end
    run(5);
    frm(72'h0803690100, 5);
    res(8'h00, 8'h2F);
  endtask
  task automatic t_reads();
    run(4);
    frm(72'h0803620100, 5);
    res(8'h00, 8'h00);
    bad_len <= 1;
    run(4);
    chk("badlen", q & 8'h04, 8'h04);
    res(8'h82, 8'h00);
    bad_len <= 0;
  endtask
  task automatic t_idle(logic [7:0] o, logic [71:0] e);
    wreg(`OFF_CTRL, o);
    wait (dev.waiting === 1'b1);
    frm(e, 9);
    chk("length", dev.nb[7:0], 8'h10);
    field <= 1;
    repeat (500) @(posedge clock);
    field <= 0;
  endtask
  initial begin
    #800000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clock);
    chk("cs in reset", pins.cs_n, 1'b1);
    chk("wake in reset", pins.wake_n, 1'b1);
    arst_n <= 1;
    repeat (3) @(posedge clock);
    t_reset();
    t_wake();
    t_analog();
    t_reads();
    t_idle(8'h03, 72'h070E0C014238001800);
    wait_stat(8'h01, 8'h00, 5000);
    res(8'h00, 8'h04);
    t_idle(8'h02, 72'h070E08040004001800);
    chk("hib stays", dev.waiting, 1'b1);
    wreg(`OFF_CTRL, 8'h01);
    wait_stat(8'h03, 8'h02, 5000);
    chk("hib woke", dev.waiting, 1'b0);
    res(8'h00, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
